/* File: verif/hvf_framer_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hvf_map.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module hvf_framer_monitor (
	input wire logic       I_CORE_CLK,
	input wire logic       I_RESET,
	input wire logic [5:0] I_AVS_ADDRESS,
	input wire logic       I_AVS_READ,
	input wire logic       I_AVS_WRITE,
	input wire logic       O_AVS_WAITREQUEST,
	input wire logic [9:0] O_WORD_Y_G,
	input wire logic       O_WORD_STROBE,
	input wire logic       O_TAKE_SAMPLE,
	input wire logic       O_FIELD,
	input wire logic       O_VBLANK,
	input wire logic       O_HBLANK
);
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RESET);
	wire [9:0] w = O_WORD_Y_G;
	reg [11:0] n_line, n_blank;
	reg        seen, prev_hb, prev_sav;
	// EAV follows active words; SAV follows blanking fill, so tell them apart
	wire eav0 = O_WORD_STROBE && O_HBLANK && w == `HVF_PREAMBLE_HI
		&& !prev_hb;
	wire flag = O_WORD_STROBE && O_HBLANK && w[9] && w != `HVF_PREAMBLE_HI;
	// Word counts per line; a mode write spoils the running line
	always @(posedge I_CORE_CLK) begin
		if (I_RESET || (I_AVS_WRITE && I_AVS_ADDRESS == `HVF_ADDR_CTRL)) begin
			seen <= 1'b0;
			n_line <= 12'h0;
			n_blank <= 12'h0;
		end else if (O_WORD_STROBE) begin
			seen <= seen | eav0;
			n_line <= eav0 ? 12'h1 : n_line + 12'h1;
			n_blank <= eav0 ? 12'h1 : n_blank + {11'h0, O_HBLANK};
		end
	end
	// Last word before the current one
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			prev_hb <= 1'b1;
			prev_sav <= 1'b0;
		end else if (O_WORD_STROBE) begin
			prev_hb <= O_HBLANK;
			prev_sav <= flag && !w[6];
		end
	end
	sequence s_zero;
		##[7:9] O_WORD_STROBE && w == `HVF_PREAMBLE_LO;
	endsequence
	property p_wait;
		$rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST
			##1 !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
	endproperty
	a_wait: assert property (p_wait) else $error("bus wait cycle wrong");
	property p_code;
		eav0 |-> s_zero ##0 s_zero ##[7:9] (flag && w[6]);
	endproperty
	a_code: assert property (p_code) else $error("bad EAV");
	property p_prot;
		flag |-> w[5] == (w[7] ^ w[6]) && w[4] == (w[8] ^ w[6])
			&& w[3] == (w[8] ^ w[7]) && w[2] == (^w[8:6]) && w[1:0] == 2'b00;
	endproperty
	a_prot: assert property (p_prot) else $error("bad protection");
	property p_flags;
		flag |-> w[8] == O_FIELD && w[7] == O_VBLANK;
	endproperty
	a_flags: assert property (p_flags) else $error("flag order");
	property p_fv;
		$changed(O_FIELD) || $changed(O_VBLANK) |-> eav0;
	endproperty
	a_fv: assert property (p_fv) else $error("F or V moved");
	property p_take;
		O_TAKE_SAMPLE |-> O_WORD_STROBE && !O_HBLANK;
	endproperty
	a_take: assert property (p_take) else $error("take outside");
	property p_clip;
		O_WORD_STROBE && !O_HBLANK |-> w >= `HVF_VIDEO_MIN
			&& w <= `HVF_VIDEO_MAX10;
	endproperty
	a_clip: assert property (p_clip) else $error("reserved level");
	property p_len;
		eav0 && seen |-> n_line == `HVF_M_1125 || n_line == `HVF_M_1250;
	endproperty
	a_len: assert property (p_len) else $error("line length");
	property p_blank;
		eav0 && seen |-> n_blank == (n_line == `HVF_M_1250 ? `HVF_K_1250
			: `HVF_K_1125) && n_line - n_blank == `HVF_ACTIVE_SAMPLES;
	endproperty
	a_blank: assert property (p_blank) else $error("blanking");
	property p_sav;
		O_WORD_STROBE && !O_HBLANK && prev_hb |-> prev_sav;
	endproperty
	a_sav: assert property (p_sav) else $error("no SAV");
endmodule // hvf_framer_monitor
bind hvf_framer hvf_framer_monitor u_mon (.I_CORE_CLK(I_CORE_CLK),
	.I_RESET(I_RESET), .I_AVS_ADDRESS(I_AVS_ADDRESS),
	.I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
	.O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_WORD_Y_G(O_WORD_Y_G),
	.O_WORD_STROBE(O_WORD_STROBE), .O_TAKE_SAMPLE(O_TAKE_SAMPLE),
	.O_FIELD(O_FIELD), .O_VBLANK(O_VBLANK), .O_HBLANK(O_HBLANK));
`default_nettype wire

/* File: verif/hvf_framer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hvf_map.vh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module hvf_framer_tb_top;
	reg         clk = 1'b0, rst = 1'b1, sclk = 1'b0, rd = 1'b0, wr = 1'b0;
	reg  [5:0]  adr = 6'h0;
	reg  [31:0] wd = 32'h0, q;
	reg  [9:0]  vy = 10'h3ff, vc = 10'h000;
	wire [31:0] rdata;
	wire        wreq, irq, stb, take;
	wire [9:0]  y;
	wire [11:0] rx_len;
	wire [7:0]  rx_lines, rx_errs;
	integer     err_total = 0, n_checks = 0, n;
	reg  [7:0]  k;
	hvf_framer uut (.I_CORE_CLK(clk), .I_RESET(rst), .I_SAMPLE_CLK(sclk),
		.I_Y(vy), .I_CB(vc), .I_CR(~vc), .I_R(vy), .I_G(vc), .I_B(vy),
		.I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
		.I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .O_WORD_Y_G(y),
		.O_WORD_C_B(), .O_WORD_R(), .O_WORD_STROBE(stb), .O_TAKE_SAMPLE(take),
		.O_FIELD(), .O_VBLANK(), .O_HBLANK(), .O_ACTIVE(), .O_IRQ(irq));
	hvf_rx_model u_rx (.i_clk(clk), .i_rst(rst), .i_strobe(stb),
		.i_word(y), .o_len(rx_len), .o_lines(rx_lines), .o_errs(rx_errs));
	// Core clock 100 ns; sample pin 800 ns, offset so phases differ
	initial forever #50 clk = ~clk;
	initial begin
		#137;
		forever #400 sclk = ~sclk;
	end
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input string nm, input reg [31:0] e, input reg [31:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				$display("MISMATCH %s exp %h got %h", nm, e, g);
				err_total = err_total + 1;
			end
		end
	endtask
	// Held until waitrequest is seen low at an edge, then released
	task bus(input reg w, input reg [5:0] a, input reg [31:0] d);
		begin
			rd <= !w;
			wr <= w;
			adr <= a;
			wd <= d;
			n = 0;
			@(posedge clk);
			while (wreq !== 1'b0 && n < 50) begin
				@(posedge clk);
				n = n + 1;
			end
			q = rdata;
			chk("wait bound", 0, n / 50);
			rd <= 1'b0;
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rchk(input reg [5:0] a, input reg [31:0] e, input string nm);
		begin
			bus(1'b0, a, 32'h0);
			chk(nm, e, q);
		end
	endtask
	// Waits for the receiver to count lines, with a bound
	task wait_lines(input reg [7:0] t);
		begin
			n = 0;
			while (rx_lines < t && n < 30000) begin
				@(posedge clk);
				n = n + 1;
			end
		end
	endtask
	// Waits for a word taken from the inputs, then checks the first lane
	task chk_take(input reg [9:0] e, input string nm);
		begin
			n = 0;
			@(posedge clk);
			while (take !== 1'b1 && n < 5000) begin
				@(posedge clk);
				n = n + 1;
			end
			chk(nm, {22'h0, e}, {22'h0, y});
		end
	endtask
	initial begin
		#8000000;
		err_total = err_total + 1;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rchk(`HVF_ADDR_CTRL, 32'h0, "ctrl");
		rchk(`HVF_ADDR_STATUS, 32'h0, "status");
		rchk(`HVF_ADDR_MASK, 32'h0, "mask");
		bus(1'b1, 6'h10, 32'hffffffff);
		rchk(6'h10, 32'h0, "unmapped");
		bus(1'b1, `HVF_ADDR_POS, 32'hffffffff);
		rchk(`HVF_ADDR_POS, 32'h40010000, "pos idle");
		bus(1'b1, `HVF_ADDR_CTRL, 32'h9);
		wait_lines(8'd2);
		chk("len 1125", 2200, {20'h0, rx_len});
		chk_take(`HVF_VIDEO_MAX8, "y clip 8");
		rchk(`HVF_ADDR_STATUS, 32'h1, "line event");
		chk("irq masked", 0, {31'h0, irq});
		bus(1'b1, `HVF_ADDR_MASK, 32'h1);
		@(posedge clk);
		chk("irq on", 1, {31'h0, irq});
		bus(1'b1, `HVF_ADDR_STATUS, 32'h1);
		@(posedge clk);
		chk("irq off", 0, {31'h0, irq});
		rchk(`HVF_ADDR_STATUS, 32'h0, "cleared");
		bus(1'b1, `HVF_ADDR_CTRL, 32'h0);
		bus(1'b1, `HVF_ADDR_CTRL, 32'h3);
		k = rx_lines + 8'd2;
		wait_lines(k);
		chk("len 1250", 2304, {20'h0, rx_len});
		chk("rx errors", 0, {24'h0, rx_errs});
		chk_take(`HVF_VIDEO_MAX10, "y clip 10");
		bus(1'b1, `HVF_ADDR_CTRL, 32'h0);
		bus(1'b1, `HVF_ADDR_CTRL, 32'h5);
		chk_take(`HVF_VIDEO_MIN, "g clip");
		k = rx_lines + 8'd2;
		wait_lines(k);
		chk("len rgb", 2200, {20'h0, rx_len});
		chk("rx errors rgb", 0, {24'h0, rx_errs});
		finish_test;
	end
endmodule // hvf_framer_tb_top
`default_nettype wire

/* File: verif/hvf_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Destination receiver: code decode
// ----------------------------------------
module hvf_rx_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_strobe,
	input  wire logic [9:0]  i_word,
	output var  logic [11:0] o_len,
	output var  logic [7:0]  o_lines,
	output var  logic [7:0]  o_errs
);
	logic [9:0]  h1, h2, h3;
	logic [11:0] cnt;
	wire  [9:0]  w = i_word;
	// Preamble seen on the last three words
	wire pre = h3 == 10'h3ff && h2 == 10'h000 && h1 == 10'h000;
	// Only bits 9..2 are trusted, as an 8-bit receiver would
	wire bad = !w[9] || w[5] != (w[7] ^ w[6]) || w[4] != (w[8] ^ w[6])
		|| w[3] != (w[8] ^ w[7]) || w[2] != (^w[8:6]);
	// Length is measured between EAV flag words, H is bit 6
	always @(posedge i_clk) begin
		if (i_rst) begin
			{h1, h2, h3} <= 30'h0;
			cnt <= 12'h0;
			o_len <= 12'h0;
			o_lines <= 8'h0;
			o_errs <= 8'h0;
		end else if (i_strobe) begin
			{h3, h2, h1} <= {h2, h1, w};
			cnt <= cnt + 12'h1;
			if (pre && bad)
				o_errs <= o_errs + 8'h1;
			if (pre && !bad && w[6]) begin
				o_len <= cnt;
				o_lines <= o_lines + 8'h1;
				cnt <= 12'h1;
			end
		end
	end
endmodule // hvf_rx_model
`default_nettype wire

/* File: verilog/hvf_framer.v */
// Function
// - Luma plus multiplexed chroma in 20-bit word
// - Chroma co-sited odd luma, Cb then Cr
// - 8-bit values get two zero LSBs
// - Video never uses reserved code levels
// - 1125-line system also carries 30-bit RGB
// - Line is 2200 or 2304 samples
// - Line begins with EAV, 88/128 before reference
// - Active 1920 samples right after SAV
// - Horizontal blanking 280 or 384 incl. codes
// - Four-word codes: preamble then flag word
// - EAV and SAV on every line
// - 8-bit uses bits 9..2; 1250 ten-bit
// - F and V change only at EAV
// - Four protection bits from F, V, H
// - 1125-line field and active line numbers
// - 1250-line field and active line numbers
// - Line counter advances at line start
// - F is MSB, H is LSB of flags
`timescale 1ns/1ns
`default_nettype none
`include "hvf_map.vh"

module hvf_framer (
	input  wire        I_CORE_CLK,
	input  wire        I_RESET,
	input  wire        I_SAMPLE_CLK,
	input  wire [9:0]  I_Y,
	input  wire [9:0]  I_CB,
	input  wire [9:0]  I_CR,
	input  wire [9:0]  I_R,
	input  wire [9:0]  I_G,
	input  wire [9:0]  I_B,
	input  wire [5:0]  I_AVS_ADDRESS,
	input  wire        I_AVS_READ,
	input  wire        I_AVS_WRITE,
	input  wire [31:0] I_AVS_WRITEDATA,
	input  wire [3:0]  I_AVS_BYTEENABLE,
	output reg  [31:0] O_AVS_READDATA,
	output reg         O_AVS_WAITREQUEST,
	output reg  [9:0]  O_WORD_Y_G,
	output reg  [9:0]  O_WORD_C_B,
	output reg  [9:0]  O_WORD_R,
	output reg         O_WORD_STROBE,
	output reg         O_TAKE_SAMPLE,
	output reg         O_FIELD,
	output reg         O_VBLANK,
	output reg         O_HBLANK,
	output reg         O_ACTIVE,
	output reg         O_IRQ
);

	// ------------------------------------------------------------
	// Sample clock pin synchroniser and edge finder
	// ------------------------------------------------------------
	reg        smp_s1;
	reg        smp_s2;
	reg        smp_s3;
	wire       smp_tick;

	// First stage feeds only the second; edge from stages two, three
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			smp_s1 <= 1'b0;
			smp_s2 <= 1'b0;
			smp_s3 <= 1'b0;
		end else begin
			smp_s1 <= I_SAMPLE_CLK;
			smp_s2 <= smp_s1;
			smp_s3 <= smp_s2;
		end
	end

	assign smp_tick = smp_s2 & ~smp_s3;

	// ------------------------------------------------------------
	// Control, status and mask registers
	// ------------------------------------------------------------
	reg  [3:0]  ctrl;
	reg  [2:0]  status;
	reg  [2:0]  mask;
	reg  [2:0]  events;
	wire        en;
	wire        sys1250;
	wire        rgb_mode;
	wire        eight;
	wire        bus_req;
	wire        bus_done;

	assign en       = ctrl[`HVF_CTRL_ENABLE];
	assign sys1250  = ctrl[`HVF_CTRL_SYS1250];
	// RGB lanes exist only in the 1125-line system
	assign rgb_mode = ctrl[`HVF_CTRL_RGB] & ~sys1250;
	// The 1250-line system always needs all ten bits
	assign eight    = ctrl[`HVF_CTRL_EIGHT] & ~sys1250;
	assign bus_req  = I_AVS_READ | I_AVS_WRITE;
	assign bus_done = bus_req & ~O_AVS_WAITREQUEST;

	// ------------------------------------------------------------
	// Line geometry for the selected system
	// ------------------------------------------------------------
	wire [11:0] line_len;
	wire [11:0] blank_len;
	wire [10:0] l3;
	wire [10:0] l4;
	wire [10:0] l7;
	wire [10:0] l9;
	wire [10:0] l10;
	wire [10:0] l12;

	assign line_len  = sys1250 ? `HVF_M_1250 : `HVF_M_1125;
	assign blank_len = sys1250 ? `HVF_K_1250 : `HVF_K_1125;
	assign l3  = sys1250 ? `HVF_L3_1250  : `HVF_L3_1125;
	assign l4  = sys1250 ? `HVF_L4_1250  : `HVF_L4_1125;
	assign l7  = sys1250 ? `HVF_L7_1250  : `HVF_L7_1125;
	assign l9  = sys1250 ? `HVF_L9_1250  : `HVF_L9_1125;
	assign l10 = sys1250 ? `HVF_L10_1250 : `HVF_L10_1125;
	assign l12 = sys1250 ? `HVF_L12_1250 : `HVF_L12_1125;

	// ------------------------------------------------------------
	// Sample and line counters
	// ------------------------------------------------------------
	reg  [11:0] cnt;
	reg  [10:0] line;
	reg         fld;
	reg         vbl;
	wire        line_end;
	reg  [10:0] next_line;
	reg         next_fld;
	reg         next_vbl;

	assign line_end = (cnt == line_len - 12'd1);

	// Flags of the line about to start, from its number
	always @* begin
		if (line == l12)
			next_line = `HVF_LINE_FIRST;
		else
			next_line = line + 11'd1;
		next_fld = (next_line >= l7);
		next_vbl = !(((next_line >= l3) && (next_line <= l4)) ||
			((next_line >= l9) && (next_line <= l10)));
	end

	// Counter advances on each sample; line wraps at EAV start
	always @(posedge I_CORE_CLK) begin
		if (I_RESET || !en) begin
			cnt  <= 12'd0;
			line <= `HVF_LINE_FIRST;
			fld  <= 1'b0;
			vbl  <= 1'b1;
		end else if (smp_tick) begin
			if (line_end) begin
				cnt  <= 12'd0;
				line <= next_line;
				fld  <= next_fld;
				vbl  <= next_vbl;
			end else begin
				cnt <= cnt + 12'd1;
			end
		end
	end

	// ------------------------------------------------------------
	// Word formation
	// ------------------------------------------------------------
	// Keeps video out of the reserved code levels
	function [9:0] hvf_clip;
		input [9:0] x;
		input       eb;
		reg   [9:0] t;
		begin
			t = eb ? {x[9:2], 2'b00} : x;
			if (t < `HVF_VIDEO_MIN)
				hvf_clip = `HVF_VIDEO_MIN;
			else if (eb && (t > `HVF_VIDEO_MAX8))
				hvf_clip = `HVF_VIDEO_MAX8;
			else if (t > `HVF_VIDEO_MAX10)
				hvf_clip = `HVF_VIDEO_MAX10;
			else
				hvf_clip = t;
		end
	endfunction

	reg  [9:0]  cr_hold;
	reg         in_eav;
	reg         in_sav;
	reg         in_act;
	reg         h_bit;
	reg  [9:0]  flag_word;
	reg  [9:0]  code_word;
	reg  [9:0]  chroma;
	reg  [9:0]  next_y_g;
	reg  [9:0]  next_c_b;
	reg  [9:0]  next_r;

	// Decode position within the line and build the lane values
	always @* begin
		in_eav = (cnt < `HVF_CODE_LEN);
		in_sav = (cnt >= blank_len - `HVF_CODE_LEN) &&
			(cnt < blank_len);
		in_act = (cnt >= blank_len);
		h_bit  = in_eav;
		// Flag word: 1 F V H P3 P2 P1 P0 0 0
		flag_word = {1'b1, fld, vbl, h_bit,
			vbl ^ h_bit, fld ^ h_bit, fld ^ vbl,
			fld ^ vbl ^ h_bit, 2'b00};
		// Code phase: both codes start on a multiple of four
		if (cnt[1:0] == 2'd0)
			code_word = `HVF_PREAMBLE_HI;
		else if (cnt[1:0] == 2'd3)
			code_word = flag_word;
		else
			code_word = `HVF_PREAMBLE_LO;
		// Even active index: odd luma, carries Cb
		chroma = cnt[0] ? cr_hold : I_CB;
		if (in_eav || in_sav) begin
			next_y_g = code_word;
			next_c_b = code_word;
			next_r   = code_word;
		end else if (in_act && rgb_mode) begin
			next_y_g = hvf_clip(I_G, eight);
			next_c_b = hvf_clip(I_B, eight);
			next_r   = hvf_clip(I_R, eight);
		end else if (in_act) begin
			next_y_g = hvf_clip(I_Y, eight);
			next_c_b = hvf_clip(chroma, eight);
			next_r   = `HVF_BLACK_Y;
		end else begin
			next_y_g = `HVF_BLACK_Y;
			next_c_b = rgb_mode ? `HVF_BLACK_Y : `HVF_BLACK_C;
			next_r   = `HVF_BLACK_Y;
		end
	end

	// Cr of a pair is taken with Cb and sent one word later
	always @(posedge I_CORE_CLK) begin
		if (I_RESET)
			cr_hold <= `HVF_BLACK_C;
		else if (smp_tick && en && in_act && !cnt[0])
			cr_hold <= I_CR;
	end

	// ------------------------------------------------------------
	// Output lanes, registered once per sample
	// ------------------------------------------------------------
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_WORD_Y_G    <= `HVF_BLACK_Y;
			O_WORD_C_B    <= `HVF_BLACK_C;
			O_WORD_R      <= `HVF_BLACK_Y;
			O_WORD_STROBE <= 1'b0;
			O_TAKE_SAMPLE <= 1'b0;
			O_FIELD       <= 1'b0;
			O_VBLANK      <= 1'b1;
			O_HBLANK      <= 1'b1;
			O_ACTIVE      <= 1'b0;
		end else begin
			O_WORD_STROBE <= smp_tick & en;
			// Tells the source which tick consumed its inputs
			O_TAKE_SAMPLE <= smp_tick & en & in_act;
			if (smp_tick && en) begin
				O_WORD_Y_G <= next_y_g;
				O_WORD_C_B <= next_c_b;
				O_WORD_R   <= next_r;
				O_FIELD    <= fld;
				O_VBLANK   <= vbl;
				O_HBLANK   <= ~in_act;
				O_ACTIVE   <= in_act & ~vbl;
			end
		end
	end

	// ------------------------------------------------------------
	// Events, sticky status and interrupt
	// ------------------------------------------------------------
	always @* begin
		events = 3'b000;
		events[`HVF_EV_LINE]  = smp_tick & en & line_end;
		events[`HVF_EV_FIELD] = smp_tick & en & line_end &
			(next_fld != fld);
		events[`HVF_EV_FRAME] = smp_tick & en & line_end &
			(next_line == `HVF_LINE_FIRST);
	end

	// A new event wins over a write-one clear in the same cycle
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			status <= 3'b000;
		end else if (bus_done && I_AVS_WRITE &&
			(I_AVS_ADDRESS == `HVF_ADDR_STATUS) &&
			I_AVS_BYTEENABLE[0]) begin
			status <= (status & ~I_AVS_WRITEDATA[2:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always @(posedge I_CORE_CLK) begin
		if (I_RESET)
			O_IRQ <= 1'b0;
		else
			O_IRQ <= |(status & mask);
	end

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait cycle for every access
	// ------------------------------------------------------------
	// Waitrequest drops one cycle after a request appears
	always @(posedge I_CORE_CLK) begin
		if (I_RESET)
			O_AVS_WAITREQUEST <= 1'b1;
		else if (bus_req && O_AVS_WAITREQUEST)
			O_AVS_WAITREQUEST <= 1'b0;
		else
			O_AVS_WAITREQUEST <= 1'b1;
	end

	// Writes take effect at the edge that completes the access
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			ctrl <= `HVF_CTRL_RESET;
			mask <= `HVF_MASK_RESET;
		end else if (bus_done && I_AVS_WRITE &&
			I_AVS_BYTEENABLE[0]) begin
			if (I_AVS_ADDRESS == `HVF_ADDR_CTRL)
				ctrl <= I_AVS_WRITEDATA[3:0];
			else if (I_AVS_ADDRESS == `HVF_ADDR_MASK)
				mask <= I_AVS_WRITEDATA[2:0];
		end
	end

	// Read data is captured in the wait cycle, so stands when done
	always @(posedge I_CORE_CLK) begin
		if (I_RESET) begin
			O_AVS_READDATA <= 32'h00000000;
		end else if (I_AVS_READ && O_AVS_WAITREQUEST) begin
			if (I_AVS_ADDRESS == `HVF_ADDR_CTRL)
				O_AVS_READDATA <= {28'h0000000, ctrl};
			else if (I_AVS_ADDRESS == `HVF_ADDR_STATUS)
				O_AVS_READDATA <= {29'h00000000, status};
			else if (I_AVS_ADDRESS == `HVF_ADDR_MASK)
				O_AVS_READDATA <= {29'h00000000, mask};
			else if (I_AVS_ADDRESS == `HVF_ADDR_POS)
				O_AVS_READDATA <= {fld, vbl, 3'b000, line,
					4'h0, cnt};
			else
				O_AVS_READDATA <= 32'h00000000;
		end
	end

endmodule // hvf_framer

`default_nettype wire

/* File: verilog/hvf_map.vh */
`ifndef HVF_MAP_VH
`define HVF_MAP_VH

// ----------------------------------------------------------------
// Register map (byte addresses on the Avalon-MM slave)
// ----------------------------------------------------------------
`define HVF_ADDR_CTRL        6'h00
`define HVF_ADDR_STATUS      6'h04
`define HVF_ADDR_MASK        6'h08
`define HVF_ADDR_POS         6'h0c

// Control fields
`define HVF_CTRL_ENABLE      0
`define HVF_CTRL_SYS1250     1
`define HVF_CTRL_RGB         2
`define HVF_CTRL_EIGHT       3
`define HVF_CTRL_RESET       4'h0

// Event bits, shared by status and mask
`define HVF_EV_LINE          0
`define HVF_EV_FIELD         1
`define HVF_EV_FRAME         2
`define HVF_MASK_RESET       3'h0

// ----------------------------------------------------------------
// Line interval, in sample clock periods
// ----------------------------------------------------------------
`define HVF_M_1125           12'd2200
`define HVF_M_1250           12'd2304
`define HVF_K_1125           12'd280
`define HVF_K_1250           12'd384
`define HVF_F_1125           12'd88
`define HVF_F_1250           12'd128
`define HVF_G_1125           12'd192
`define HVF_G_1250           12'd256
`define HVF_ACTIVE_SAMPLES   12'd1920
`define HVF_CODE_LEN         12'd4

// ----------------------------------------------------------------
// Field interval, digital line numbers
// ----------------------------------------------------------------
`define HVF_L3_1125          11'd41
`define HVF_L4_1125          11'd557
`define HVF_L7_1125          11'd564
`define HVF_L9_1125          11'd603
`define HVF_L10_1125         11'd1120
`define HVF_L12_1125         11'd1125
`define HVF_L3_1250          11'd45
`define HVF_L4_1250          11'd620
`define HVF_L7_1250          11'd626
`define HVF_L9_1250          11'd670
`define HVF_L10_1250         11'd1245
`define HVF_L12_1250         11'd1250
`define HVF_LINE_FIRST       11'd1

// ----------------------------------------------------------------
// Code levels (10-bit, two fractional bits)
// ----------------------------------------------------------------
`define HVF_PREAMBLE_HI      10'h3ff
`define HVF_PREAMBLE_LO      10'h000
`define HVF_VIDEO_MIN        10'h004
`define HVF_VIDEO_MAX10      10'h3fb
`define HVF_VIDEO_MAX8       10'h3f8
`define HVF_BLACK_Y          10'h040
`define HVF_BLACK_C          10'h200

`endif
